// file: verilog/sac_pkg.sv
// What this block does
// - chain low: shared pin enables serial output
// - chain high: shared pin is upstream data
// - convert rising edge wakes and starts conversion
// - busy high during conversion, low after
// - each serial clock rise while not busy (and, with chain low, while the shared pin is low) shifts next bit MSB-first
// - conversion end assembles eighteen-bit output word
// - result is straight unsigned binary
// - acquire, then successive approximation MSB first
// - conversion timed by internal oscillator only
// - powers down automatically after each conversion unless a convert edge comes in the done cycle
// - result readable right after conversion, no latency
`default_nettype none
package sac_pkg;
  localparam int RES_BITS = 18;
  localparam int CORE_CLK_HZ = 20000000;
  // conversion time in nanoseconds, turned into core clock cycles and split into one step per bit
  localparam int CONV_TIME_NS = 1000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * (CORE_CLK_HZ / 1000000) + 999) / 1000;
  localparam int STEP_CYCLES = (CONV_CYCLES / RES_BITS) < 1 ? 1 : (CONV_CYCLES / RES_BITS);
  localparam int REINIT_TIME_US = 20;
  localparam logic [RES_BITS-1:0] WORD_RESET = 18'h00000;
  localparam logic [4:0] BIT_TOP = 5'h11;
  // weight of the least significant trial bit
  localparam logic [RES_BITS-1:0] WEIGHT_LSB = 18'h00001;
  // synchroniser reset: the shared pin idles high (output off), the others low
  localparam logic [3:0] SYNC_RESET = 4'h1;
  typedef enum logic [1:0] {SAC_POWER_DOWN, SAC_CONVERT, SAC_DONE} sac_state_t;
endpackage
`default_nettype wire

// file: verilog/sac_top.sv
`timescale 1ns/1ps
`default_nettype none
module sac_top (
  input wire logic I_CORE_CLK,
  input wire logic I_SYS_RST,
  input wire logic I_CONVERT_START,
  input wire logic I_SCK,
  input wire logic I_CHAIN_SELECT,
  input wire logic I_READOUT_ENABLE_OR_CHAIN_IN,
  input wire logic [sac_pkg::RES_BITS-1:0] I_ANALOG_CODE,
  output logic O_BUSY,
  output logic O_SDO,
  output logic O_SDO_OE,
  output logic O_POWERED_UP
);
  import sac_pkg::*;

  // two-flop synchronisers for every pin from outside the core clock; only the
  // second stage is read, so a metastable first stage never reaches the logic
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic cnv_prev;
  logic sck_prev;
  // the analog stand-in code is a word from outside the clock domain too; the host
  // holds it steady before the convert edge, and its stages keep pace with the
  // convert synchroniser, so the word is only taken once it has settled
  logic [RES_BITS-1:0] code_a;
  logic [RES_BITS-1:0] code_b;
  // reset to the idle level of each pin, so no false edge or enable follows reset
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      sync_a <= SYNC_RESET;
      sync_b <= SYNC_RESET;
      cnv_prev <= 1'b0;
      sck_prev <= 1'b0;
      code_a <= WORD_RESET;
      code_b <= WORD_RESET;
    end else begin
      sync_a <= {I_CONVERT_START, I_SCK, I_CHAIN_SELECT, I_READOUT_ENABLE_OR_CHAIN_IN};
      sync_b <= sync_a;
      cnv_prev <= sync_b[3];
      sck_prev <= sync_b[2];
      code_a <= I_ANALOG_CODE;
      code_b <= code_a;
    end
  end

  // edge finders and mode decode, all read from the second synchroniser stage
  logic cnv_rise;
  logic sck_rise;
  logic chain_mode;
  logic shared_pin;
  assign cnv_rise = sync_b[3] & ~cnv_prev;
  assign sck_rise = sync_b[2] & ~sck_prev;
  assign chain_mode = sync_b[1];
  assign shared_pin = sync_b[0];

  // the trial weight of one bit position
  function automatic logic [RES_BITS-1:0] weight_of(input logic [4:0] idx);
    return WEIGHT_LSB << idx;
  endfunction

  // a trial bit is kept when the held sample is at or above the trial word;
  // the compare is unsigned, since the result is straight binary
  function automatic logic keep_bit(input logic [RES_BITS-1:0] acc, input logic [RES_BITS-1:0] smp,
                                    input logic [4:0] idx);
    return (acc | weight_of(idx)) <= smp;
  endfunction

  // shifting only while idle and, in normal mode, only while the enable is low
  function automatic logic may_shift(input logic chain, input logic pin, input logic conv);
    return !conv && (chain || !pin);
  endfunction

  // conversion sequencer; only the core clock paces it, never the serial clock
  sac_state_t state;
  sac_state_t next_state;
  logic [7:0] step_cnt;
  logic [7:0] next_step_cnt;
  logic [4:0] bit_idx;
  logic [4:0] next_bit_idx;
  logic [RES_BITS-1:0] sample;
  logic [RES_BITS-1:0] next_sample;
  logic [RES_BITS-1:0] trial;
  logic [RES_BITS-1:0] next_trial;
  logic [RES_BITS-1:0] shreg;
  logic [RES_BITS-1:0] next_shreg;
  logic busy;
  logic next_busy;
  logic sdo;
  logic next_sdo;
  logic sdo_oe;
  logic next_sdo_oe;
  logic pwr;
  logic next_pwr;

  always_comb begin
    next_state = state;
    next_step_cnt = step_cnt;
    next_bit_idx = bit_idx;
    next_sample = sample;
    next_trial = trial;
    next_shreg = shreg;
    next_busy = busy;
    next_pwr = pwr;
    unique case (state)
      SAC_POWER_DOWN, SAC_DONE: begin
        if (cnv_rise) begin
          // sample held at the edge; acquisition is the idle time before it
          next_state = SAC_CONVERT;
          next_sample = code_b;
          next_trial = WORD_RESET;
          next_bit_idx = BIT_TOP;
          next_step_cnt = 8'h00;
          next_busy = 1'b1;
          next_pwr = 1'b1;
        end else if (state == SAC_DONE) begin
          next_state = SAC_POWER_DOWN;
          next_pwr = 1'b0;
        end
      end
      SAC_CONVERT: begin
        if (step_cnt == 8'(STEP_CYCLES - 1)) begin
          next_step_cnt = 8'h00;
          // keep the trial bit if the sample is at or above it (unsigned compare)
          if (keep_bit(trial, sample, bit_idx)) begin
            next_trial = trial | weight_of(bit_idx);
          end
          if (bit_idx == 5'h00) begin
            next_state = SAC_DONE;
            next_busy = 1'b0;
          end else begin
            next_bit_idx = bit_idx - 5'h01;
          end
        end else begin
          next_step_cnt = step_cnt + 8'h01;
        end
      end
    endcase
    // serial shifter; loading on busy fall gives the word with no latency, and a
    // serial clock edge in that same cycle is dropped since busy still stands
    if (state == SAC_CONVERT && next_state == SAC_DONE) begin
      next_shreg = next_trial;
    end else if (sck_rise && may_shift(chain_mode, shared_pin, busy)) begin
      next_shreg = {shreg[RES_BITS-2:0], chain_mode ? shared_pin : 1'b0};
    end
  end

  // output drive: enable follows the shared pin in normal mode, always on in chain
  always_comb begin
    next_sdo = next_shreg[RES_BITS-1];
    next_sdo_oe = chain_mode ? 1'b1 : !shared_pin;
  end

  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      state <= SAC_POWER_DOWN;
      step_cnt <= 8'h00;
      bit_idx <= 5'h00;
      sample <= WORD_RESET;
      trial <= WORD_RESET;
      shreg <= WORD_RESET;
      busy <= 1'b0;
      sdo <= 1'b0;
      sdo_oe <= 1'b0;
      pwr <= 1'b0;
    end else begin
      state <= next_state;
      step_cnt <= next_step_cnt;
      bit_idx <= next_bit_idx;
      sample <= next_sample;
      trial <= next_trial;
      shreg <= next_shreg;
      busy <= next_busy;
      sdo <= next_sdo;
      sdo_oe <= next_sdo_oe;
      pwr <= next_pwr;
    end
  end

  assign O_BUSY = busy;
  assign O_SDO = sdo;
  assign O_SDO_OE = sdo_oe;
  assign O_POWERED_UP = pwr;

  // helper for the checks: cycles of the current busy stretch
  logic [7:0] busy_len;
  logic [7:0] next_busy_len;
  always_comb begin
    next_busy_len = busy ? busy_len + 8'h01 : 8'h00;
  end
  // registered copy of the count
  always_ff @(posedge I_CORE_CLK or posedge I_SYS_RST) begin
    if (I_SYS_RST) begin
      busy_len <= 8'h00;
    end else begin
      busy_len <= next_busy_len;
    end
  end

  // busy rises one edge after the synchronised convert edge is seen
  a_busy_on_start: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) (cnv_rise && state != SAC_CONVERT) |=> busy)
    else $error("busy not raised");

  // a conversion never ends within its first eight cycles
  a_conv_length: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) $rose(busy) |-> busy [*8])
    else $error("conversion ended too early");

  // busy lasts exactly one oscillator step per result bit
  a_conv_exact: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) $fell(busy) |-> busy_len == 8'(RES_BITS * STEP_CYCLES))
    else $error("conversion length wrong");

  // busy only drops when the sequencer has finished
  a_busy_ends_done: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) $fell(busy) |-> state == SAC_DONE)
    else $error("busy dropped before the end");

  // the finished word equals the held sample in the cycle busy falls
  a_word_ready: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) $fell(busy) |-> shreg == sample)
    else $error("result word differs from sample");

  // the serial output shows the most significant bit as busy falls
  a_msb_first: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) $fell(busy) |-> sdo == sample[RES_BITS-1])
    else $error("first serial bit wrong");

  // the power flag drops one cycle after the conversion ends
  a_power_down: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) (state == SAC_DONE && !cnv_rise) |=> !pwr)
    else $error("no auto power down");

  // asleep and idle until the next convert edge
  a_stay_asleep: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) (state == SAC_POWER_DOWN && !cnv_rise) |=> (!pwr && !busy))
    else $error("woke without a convert edge");

  // never converting while powered down
  a_busy_powered: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) busy |-> pwr)
    else $error("busy while powered down");

  // the convert edge wakes the converter together with busy
  a_wake: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) $rose(busy) |-> pwr)
    else $error("converting while powered down");

  // a convert edge during a conversion leaves the held sample alone
  a_ignore_convert: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) (busy && cnv_rise) |=> sample == $past(sample))
    else $error("conversion restarted");

  // every conversion starts from the most significant bit with an empty trial
  a_start_msb: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (cnv_rise && state != SAC_CONVERT) |=> (bit_idx == BIT_TOP && trial == WORD_RESET))
    else $error("conversion not started at the top bit");

  // one bit position per oscillator step, downwards
  a_bit_step: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (state == SAC_CONVERT && step_cnt == 8'(STEP_CYCLES - 1) && bit_idx != 5'h00) |=> bit_idx == $past(bit_idx) - 5'h01)
    else $error("bit sequence skipped");

  // the trial word never passes the unsigned sample
  a_trial_bound: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) state == SAC_CONVERT |-> trial <= sample)
    else $error("trial word above sample");

  // in normal mode the enable follows the shared pin, active low
  a_normal_enable: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) !chain_mode |=> sdo_oe == !$past(shared_pin))
    else $error("enable wrong in normal mode");

  // in chain mode the output is always driven
  a_chain_enable: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) chain_mode |=> sdo_oe)
    else $error("output off in chain mode");

  // in normal mode with the enable high a serial clock edge moves nothing
  a_enable_gate: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (sck_rise && !busy && !chain_mode && shared_pin) |=> shreg == $past(shreg))
    else $error("shifted while disabled");

  // each accepted serial clock edge moves the word up by one
  a_shift_step: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (sck_rise && !busy && state != SAC_CONVERT && (chain_mode || !shared_pin))
    |=> shreg[RES_BITS-1:1] == $past(shreg[RES_BITS-2:0]))
    else $error("shift wrong");

  // zeros follow the word out in normal mode
  a_zero_fill: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (sck_rise && !busy && !chain_mode && !shared_pin) |=> !shreg[0])
    else $error("normal mode fill not zero");

  // in chain mode the upstream bit enters at the bottom
  a_chain_in: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST)
    (sck_rise && !busy && state != SAC_CONVERT && chain_mode) |=> shreg[0] == $past(shared_pin))
    else $error("chain bit not taken");

  // serial clock edges during a conversion leave the word alone
  a_busy_holds_word: assert property (
    @(posedge I_CORE_CLK) disable iff (I_SYS_RST) (sck_rise && busy) |=> (shreg == $past(shreg) || !busy))
    else $error("shifted while busy");
endmodule
`default_nettype wire

// file: tb/sac_host.sv
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  input wire logic i_clk,
  output logic o_convert,
  output logic o_sck,
  output logic o_pin
);
  // idle host: no convert, serial clock parked low, shared pin high
  initial begin
    o_convert = 1'b0;
    o_sck = 1'b0;
    o_pin = 1'b1;
  end
  // two-cycle pulse so the synchroniser surely sees the rise
  task automatic pulse();
    @(negedge i_clk) o_convert = 1'b1;
    repeat (2) @(negedge i_clk);
    o_convert = 1'b0;
  endtask
  // n clocks, 8 core cycles each; pin pattern sent msb first
  task automatic bits(input int n, input logic [35:0] d);
    @(negedge i_clk);
    // the pin moves with the clock fall, so one bit period is 8 core cycles
    for (int i = 0; i < n; i++) begin
      o_pin = d[35-i];
      repeat (4) @(negedge i_clk);
      o_sck = 1'b1;
      repeat (4) @(negedge i_clk);
      o_sck = 1'b0;
    end
    // released pin must not keep its last level
    o_pin = ~o_pin;
  endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sac_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic chain = 1'b0;
  logic [RES_BITS-1:0] code = 18'h00000;
  logic convert_start, sck, pin, busy, sdo, oe, pwr;
  logic q[$];
  int n_mismatch = 0;
  int n_tests = 0;
  int t, k, cyc;
  logic [31:0] rs = 32'hD842ADC6;
  initial forever #25 clk = ~clk;
  sac_top dut (.I_CORE_CLK(clk), .I_SYS_RST(rst), .I_CONVERT_START(convert_start), .I_SCK(sck),
    .I_CHAIN_SELECT(chain), .I_READOUT_ENABLE_OR_CHAIN_IN(pin), .I_ANALOG_CODE(code),
    .O_BUSY(busy), .O_SDO(sdo), .O_SDO_OE(oe), .O_POWERED_UP(pwr));
  sac_host host (.i_clk(clk), .o_convert(convert_start), .o_sck(sck), .o_pin(pin));
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    return v ^ (v << 5);
  endfunction
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // bounded wait; running out ends the run
  task automatic wait_busy(input logic lvl);
    for (k = 0; k < 64 && busy !== lvl; k++) @(negedge clk);
    if (busy !== lvl) begin
      n_mismatch++;
      summarize();
    end
  endtask
  // each bit is judged at the clock rise, before it moves on
  always @(posedge sck) if (q.size() > 0) check(36'(sdo), 36'(q.pop_front()));
  task automatic one_test(input logic [17:0] c, input logic ch, input logic [17:0] up);
    logic [35:0] w;
    @(negedge clk);
    code = c;
    chain = ch;
    host.pulse();
    wait_busy(1'b1);
    check(36'(pwr), 36'h1);
    cyc = 0;
    // in chain runs a second convert edge and a new code land mid-conversion
    if (ch) begin
      code = ~c;
      host.pulse();
      cyc = 3;
    end
    while (busy === 1'b1 && cyc < 99) begin
      @(negedge clk);
      cyc++;
    end
    if (busy === 1'b1) begin
      n_mismatch++;
      summarize();
    end
    check(36'(cyc), 36'(RES_BITS * STEP_CYCLES));
    // normal mode with enable high: clocks must not move the word
    if (!ch) begin
      check(36'(oe), 36'h0);
      host.bits(3, 36'hFFFFFFFFF);
    end
    w = {c, up};
    for (int i = 0; i < (ch ? 36 : 18); i++) q.push_back(w[35-i]);
    // normal mode keeps the enable low for the whole word
    host.bits(ch ? 36 : 18, ch ? {up, 18'h00000} : 36'h000000000);
    repeat (5) @(negedge clk);
    check(36'(oe), 36'(ch));
    check(36'(pwr), 36'h0);
    check(36'(q.size()), 36'h0);
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst = 1'b0;
    // keep off the convert pin for the whole reinit time after power-on
    repeat (REINIT_TIME_US * (CORE_CLK_HZ / 1000000)) @(negedge clk);
    for (t = 0; t < 6; t++) begin
      rs = xs(rs);
      one_test(t == 0 ? 18'h00000 : (t == 1 ? 18'h3FFFF : rs[17:0]), t > 3, rs[31:14]);
      $display("test %0d done", t);
    end
    summarize();
  end
endmodule
`default_nettype wire
